//--- bpv_sequencer.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

module bpv_sequencer
   import bpv_pkg::*;
#(
   parameter logic [`BPV_TMR_W-1:0] ERASE_PULSE_CYC = `BPV_TMR_W'(`BPV_ERASE_PULSE_CYC)
)(
   input  wire logic                   CLK,
   input  wire logic                   RESET_N,
   input  wire logic                   START,
   input  wire bpv_op_t                OP,
   input  wire logic [`BPV_ADDR_W-1:0] ADDR,
   input  wire logic [`BPV_DATA_W-1:0] DATA,
   input  wire logic                   SVC_REQ,
   input  wire logic                   SUPPLY_READY,
   input  wire logic [`BPV_DATA_W-1:0] FLASH_DQ_IN,
   output      bpv_flash_out_t         FLASH_O,
   output      logic                   PROGRAM_SUPPLY_HIGH,
   output      logic                   BUSY,
   output      logic                   DONE,
   output      logic                   FAIL,
   output      logic [`BPV_DATA_W-1:0] RESULT
);

   localparam logic [`BPV_TMR_W-1:0] SETTLE_CYC   = `BPV_TMR_W'(`BPV_SETTLE_CYC);
   localparam logic [`BPV_TMR_W-1:0] PULSE_CYC    = `BPV_TMR_W'(`BPV_PROG_PULSE_CYC);
   localparam logic [`BPV_TMR_W-1:0] RECOVERY_CYC = `BPV_TMR_W'(`BPV_RECOVERY_CYC);

   bpv_seq_st_t                st_ff;
   bpv_seq_st_t                nxt_st;
   bpv_bus_req_t               bus_req;
   logic                       bus_done;
   logic [`BPV_DATA_W-1:0]     bus_rdata;
   logic                       tmr_start;
   logic                       tmr_stop;
   logic [`BPV_TMR_W-1:0]      tmr_load;
   logic                       tmr_expired;

   function automatic bpv_bus_req_t wr_req(input logic [`BPV_ADDR_W-1:0] a,
                                           input logic [`BPV_DATA_W-1:0] d,
                                           input logic                   v);
      bpv_bus_req_t r;
      r.valid = v;
      r.rd    = 1'b0;
      r.addr  = a;
      r.data  = d;
      return r;
   endfunction

   function automatic bpv_bus_req_t rd_req(input logic [`BPV_ADDR_W-1:0] a,
                                           input logic                   v);
      bpv_bus_req_t r;
      r.valid = v;
      r.rd    = 1'b1;
      r.addr  = a;
      r.data  = '0;
      return r;
   endfunction

   // each bus or timer step is issued once, then the state waits for its completion, or in the pulse states for SVC_REQ
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      bus_req = '0;
      tmr_start = 1'b0;
      tmr_stop = 1'b0;
      tmr_load = '0;
      unique case (st_ff.state)
         BPV_S_IDLE: begin
            if (START) begin
               nxt_st.busy = 1'b1;
               nxt_st.fail = 1'b0;
               nxt_st.issued = 1'b0;
               nxt_st.pcnt = '0;
               nxt_st.ecnt = '0;
               unique case (OP)
                  BPV_OP_PROG: begin
                     nxt_st.preprog = 1'b0;
                     nxt_st.addr = ADDR;
                     nxt_st.data = DATA;
                     nxt_st.supply = 1'b1;
                     nxt_st.state = BPV_S_SETTLE;
                  end
                  BPV_OP_ERASE: begin
                     nxt_st.preprog = 1'b1;
                     nxt_st.addr = '0;
                     nxt_st.data = `BPV_PREPROG_DATA;
                     nxt_st.supply = 1'b1;
                     nxt_st.state = BPV_S_SETTLE;
                  end
                  default: begin
                     nxt_st.state = BPV_S_RST1;
                  end
               endcase
            end
         end
         BPV_S_SETTLE: begin
            // settle timing starts only once the supply reports its final level
            if (SUPPLY_READY) begin
               tmr_start = !st_ff.issued;
               tmr_load = SETTLE_CYC;
               nxt_st.issued = 1'b1;
               if (tmr_expired) begin
                  nxt_st.issued = 1'b0;
                  nxt_st.state = BPV_S_PG_SETUP;
               end
            end
         end
         BPV_S_PG_SETUP: begin
            bus_req = wr_req(st_ff.addr, `BPV_CMD_PROG_SETUP, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_PG_WRITE;
            end
         end
         BPV_S_PG_WRITE: begin
            bus_req = wr_req(st_ff.addr, st_ff.data, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.pcnt = st_ff.pcnt + 5'h1;
               nxt_st.state = BPV_S_PG_PULSE;
            end
         end
         BPV_S_PG_PULSE: begin
            tmr_start = !st_ff.issued;
            tmr_load = PULSE_CYC;
            nxt_st.issued = 1'b1;
            if (tmr_expired || (st_ff.issued && SVC_REQ)) begin
               tmr_stop = !tmr_expired;
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_PG_VCMD;
            end
         end
         BPV_S_PG_VCMD: begin
            // address lines repeat the byte, the device ignores them here
            bus_req = wr_req(st_ff.addr, `BPV_CMD_PROG_VERIFY, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_PG_RECOVER;
            end
         end
         BPV_S_PG_RECOVER: begin
            tmr_start = !st_ff.issued;
            tmr_load = RECOVERY_CYC;
            nxt_st.issued = 1'b1;
            if (tmr_expired) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_PG_READ;
            end
         end
         BPV_S_PG_READ: begin
            bus_req = rd_req(st_ff.addr, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.result = bus_rdata;
               if (bus_rdata == st_ff.data) begin
                  nxt_st.pcnt = '0;
                  if (!st_ff.preprog) begin
                     nxt_st.state = BPV_S_RST1;
                  end else if (st_ff.addr == `BPV_LAST_ADDR) begin
                     nxt_st.preprog = 1'b0;
                     nxt_st.addr = '0;
                     nxt_st.state = BPV_S_ER_SETUP;
                  end else begin
                     nxt_st.addr = st_ff.addr + `BPV_ADDR_W'(1);
                     nxt_st.state = BPV_S_PG_SETUP;
                  end
               end else if (st_ff.pcnt >= `BPV_PROG_PULSE_MAX) begin
                  nxt_st.fail = 1'b1;
                  nxt_st.state = BPV_S_RST1;
               end else begin
                  nxt_st.state = BPV_S_PG_SETUP;
               end
            end
         end
         BPV_S_ER_SETUP, BPV_S_ER_WRITE: begin
            bus_req = wr_req(st_ff.addr, `BPV_CMD_ERASE, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               if (st_ff.state == BPV_S_ER_SETUP) begin
                  nxt_st.state = BPV_S_ER_WRITE;
               end else begin
                  nxt_st.ecnt = st_ff.ecnt + 10'h1;
                  nxt_st.state = BPV_S_ER_PULSE;
               end
            end
         end
         BPV_S_ER_PULSE: begin
            tmr_start = !st_ff.issued;
            tmr_load = ERASE_PULSE_CYC;
            nxt_st.issued = 1'b1;
            if (tmr_expired || (st_ff.issued && SVC_REQ)) begin
               tmr_stop = !tmr_expired;
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_ER_VCMD;
            end
         end
         BPV_S_ER_VCMD: begin
            bus_req = wr_req(st_ff.addr, `BPV_CMD_ERASE_VERIFY, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_ER_RECOVER;
            end
         end
         BPV_S_ER_RECOVER: begin
            tmr_start = !st_ff.issued;
            tmr_load = RECOVERY_CYC;
            nxt_st.issued = 1'b1;
            if (tmr_expired) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = BPV_S_ER_READ;
            end
         end
         BPV_S_ER_READ: begin
            bus_req = rd_req(st_ff.addr, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.result = bus_rdata;
               if (bus_rdata == `BPV_ERASED_DATA) begin
                  if (st_ff.addr == `BPV_LAST_ADDR) begin
                     nxt_st.state = BPV_S_RST1;
                  end else begin
                     nxt_st.addr = st_ff.addr + `BPV_ADDR_W'(1);
                     nxt_st.state = BPV_S_ER_VCMD;
                  end
               end else if (st_ff.ecnt >= `BPV_ERASE_PULSE_MAX) begin
                  nxt_st.fail = 1'b1;
                  nxt_st.state = BPV_S_RST1;
               end else begin
                  nxt_st.state = BPV_S_ER_SETUP;
               end
            end
         end
         BPV_S_RST1, BPV_S_RST2: begin
            // always two resets: harmless outside the armed state, and no need to track it
            bus_req = wr_req(st_ff.addr, `BPV_CMD_RESET, !st_ff.issued);
            nxt_st.issued = 1'b1;
            if (bus_done) begin
               nxt_st.issued = 1'b0;
               nxt_st.state = st_ff.state == BPV_S_RST1 ? BPV_S_RST2 : BPV_S_FINISH;
            end
         end
         BPV_S_FINISH: begin
            nxt_st.supply = 1'b0;
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.state = BPV_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_ff <= '{state: BPV_S_IDLE, issued: 1'b0, preprog: 1'b0, addr: '0, data: '0,
                    pcnt: '0, ecnt: '0, supply: 1'b0, busy: 1'b0, done: 1'b0,
                    fail: 1'b0, result: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   bpv_bus_cycle u_bus (
      .clk     (CLK),
      .reset_n (RESET_N),
      .req     (bus_req),
      .dq_in   (FLASH_DQ_IN),
      .done    (bus_done),
      .rdata   (bus_rdata),
      .pins    (FLASH_O)
   );

   bpv_timer u_tmr (
      .clk     (CLK),
      .reset_n (RESET_N),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .load    (tmr_load),
      .expired (tmr_expired)
   );

   assign PROGRAM_SUPPLY_HIGH = st_ff.supply;
   assign BUSY                = st_ff.busy;
   assign DONE                = st_ff.done;
   assign FAIL                = st_ff.fail;
   assign RESULT              = st_ff.result;

endmodule

//--- bpv_consts.svh
`ifndef BPV_CONSTS_SVH
`define BPV_CONSTS_SVH

`define BPV_CLK_MHZ          40
`define BPV_ADDR_W           16
`define BPV_DATA_W           8
`define BPV_TMR_W            20
`define BPV_LAST_ADDR        16'hFFFF

`define BPV_CMD_PROG_SETUP   8'h40
`define BPV_CMD_PROG_VERIFY  8'hC0
`define BPV_CMD_ERASE        8'h20
`define BPV_CMD_ERASE_VERIFY 8'hA0
`define BPV_CMD_RESET        8'hFF
`define BPV_PREPROG_DATA     8'h00
`define BPV_ERASED_DATA      8'hFF

`define BPV_PROG_PULSE_MAX   5'h19
`define BPV_ERASE_PULSE_MAX  10'h3E8

`define BPV_SETTLE_NS        100
`define BPV_PROG_PULSE_NS    10000
`define BPV_RECOVERY_NS      6000
`define BPV_ERASE_PULSE_NS   10000000
`define BPV_NS_TO_CYC(ns)    (((ns) * `BPV_CLK_MHZ + 999) / 1000)
`define BPV_SETTLE_CYC       `BPV_NS_TO_CYC(`BPV_SETTLE_NS)
`define BPV_PROG_PULSE_CYC   `BPV_NS_TO_CYC(`BPV_PROG_PULSE_NS)
`define BPV_RECOVERY_CYC     `BPV_NS_TO_CYC(`BPV_RECOVERY_NS)
`define BPV_ERASE_PULSE_CYC  `BPV_NS_TO_CYC(`BPV_ERASE_PULSE_NS)

`define BPV_WE_LOW_CYC       3'h2
`define BPV_READ_CYC         3'h4

`endif

//--- bpv_pkg.sv
`include "bpv_consts.svh"

package bpv_pkg;

   typedef enum logic [1:0] {BPV_OP_PROG, BPV_OP_ERASE, BPV_OP_ABORT} bpv_op_t;

   typedef struct packed {
      logic                    ce_n;
      logic                    oe_n;
      logic                    we_n;
      logic                    dq_oe_n;
      logic [`BPV_ADDR_W-1:0]  addr;
      logic [`BPV_DATA_W-1:0]  dq;
   } bpv_flash_out_t;

   typedef struct packed {
      logic                    valid;
      logic                    rd;
      logic [`BPV_ADDR_W-1:0]  addr;
      logic [`BPV_DATA_W-1:0]  data;
   } bpv_bus_req_t;

   typedef enum {BPV_B_IDLE, BPV_B_SETUP, BPV_B_WE_LOW, BPV_B_HOLD, BPV_B_READ} bpv_bus_e_t;

   typedef struct packed {
      bpv_bus_e_t              phase;
      logic                    rd;
      logic [2:0]              cnt;
      logic                    done;
      logic [`BPV_DATA_W-1:0]  rdata;
      bpv_flash_out_t          pins;
   } bpv_bus_st_t;

   typedef struct packed {
      logic                    run;
      logic                    expired;
      logic [`BPV_TMR_W-1:0]   cnt;
   } bpv_tmr_st_t;

   typedef enum {BPV_S_IDLE, BPV_S_SETTLE, BPV_S_PG_SETUP, BPV_S_PG_WRITE, BPV_S_PG_PULSE,
                 BPV_S_PG_VCMD, BPV_S_PG_RECOVER, BPV_S_PG_READ, BPV_S_ER_SETUP,
                 BPV_S_ER_WRITE, BPV_S_ER_PULSE, BPV_S_ER_VCMD, BPV_S_ER_RECOVER,
                 BPV_S_ER_READ, BPV_S_RST1, BPV_S_RST2, BPV_S_FINISH} bpv_seq_e_t;

   typedef struct packed {
      bpv_seq_e_t              state;
      logic                    issued;
      logic                    preprog;
      logic [`BPV_ADDR_W-1:0]  addr;
      logic [`BPV_DATA_W-1:0]  data;
      logic [4:0]              pcnt;
      logic [9:0]              ecnt;
      logic                    supply;
      logic                    busy;
      logic                    done;
      logic                    fail;
      logic [`BPV_DATA_W-1:0]  result;
   } bpv_seq_st_t;

endpackage

//--- bpv_timer.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

module bpv_timer
   import bpv_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic                  start,
   input  wire logic                  stop,
   input  wire logic [`BPV_TMR_W-1:0] load,
   output      logic                  expired
);

   bpv_tmr_st_t st_ff;
   bpv_tmr_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.expired = 1'b0;
      if (start) begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = load;
      end else if (stop) begin
         nxt_st.run = 1'b0;
      end else if (st_ff.run) begin
         if (st_ff.cnt <= `BPV_TMR_W'(1)) begin
            nxt_st.run = 1'b0;
            nxt_st.expired = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - `BPV_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign expired = st_ff.expired;

endmodule

//--- bpv_bus_cycle.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

module bpv_bus_cycle
   import bpv_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire bpv_bus_req_t          req,
   input  wire logic [`BPV_DATA_W-1:0] dq_in,
   output      logic                  done,
   output      logic [`BPV_DATA_W-1:0] rdata,
   output      bpv_flash_out_t        pins
);

   localparam bpv_flash_out_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                             dq_oe_n: 1'b1, addr: '0, dq: '0};

   bpv_bus_st_t st_ff;
   bpv_bus_st_t nxt_st;

   // address is set up a cycle before the strobe falls, data held a cycle after it rises
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      unique case (st_ff.phase)
         BPV_B_IDLE: begin
            if (req.valid) begin
               nxt_st.phase = BPV_B_SETUP;
               nxt_st.rd = req.rd;
               nxt_st.pins.addr = req.addr;
               nxt_st.pins.dq = req.data;
               nxt_st.pins.ce_n = 1'b0;
               nxt_st.pins.dq_oe_n = req.rd;
            end
         end
         BPV_B_SETUP: begin
            nxt_st.cnt = 3'h1;
            if (st_ff.rd) begin
               nxt_st.phase = BPV_B_READ;
               nxt_st.pins.oe_n = 1'b0;
            end else begin
               nxt_st.phase = BPV_B_WE_LOW;
               nxt_st.pins.we_n = 1'b0;
            end
         end
         BPV_B_WE_LOW: begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == `BPV_WE_LOW_CYC) begin
               nxt_st.phase = BPV_B_HOLD;
               nxt_st.pins.we_n = 1'b1;
            end
         end
         BPV_B_HOLD: begin
            nxt_st.phase = BPV_B_IDLE;
            nxt_st.pins = PINS_IDLE;
            nxt_st.pins.addr = st_ff.pins.addr;
            nxt_st.done = 1'b1;
         end
         BPV_B_READ: begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == `BPV_READ_CYC) begin
               nxt_st.phase = BPV_B_IDLE;
               nxt_st.rdata = dq_in;
               nxt_st.pins = PINS_IDLE;
               nxt_st.pins.addr = st_ff.pins.addr;
               nxt_st.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= '{phase: BPV_B_IDLE, rd: 1'b0, cnt: 3'h0, done: 1'b0, rdata: '0,
                    pins: PINS_IDLE};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign done  = st_ff.done;
   assign rdata = st_ff.rdata;
   assign pins  = st_ff.pins;

endmodule

//--- bpv_seq_chk.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

module bpv_seq_chk
   import bpv_pkg::*;
(
   input wire logic           CLK,
   input wire logic           RESET_N,
   input wire logic           START,
   input wire logic           SUPPLY_READY,
   input wire bpv_flash_out_t FLASH_O,
   input wire logic           PROGRAM_SUPPLY_HIGH,
   input wire logic           BUSY,
   input wire logic           DONE,
   input wire logic           FAIL
);
   logic        we_ff;
   logic        arm_ff;
   logic        vfy_ff;
   logic [2:0]  rdy_ff;
   logic [4:0]  pc_ff;
   logic [9:0]  gap_ff;
   logic [15:0] adr_ff;
   logic        rise;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   assign rise = FLASH_O.we_n && !we_ff;

   // arm_ff marks a program write, so pulses count per byte and not per command
   always_ff @(posedge CLK) begin
      we_ff <= FLASH_O.we_n;
      if (!RESET_N) begin
         arm_ff <= 1'h0;
         vfy_ff <= 1'h0;
         rdy_ff <= 3'h0;
         pc_ff  <= 5'h00;
         gap_ff <= 10'h000;
         adr_ff <= 16'h0000;
      end else begin
         rdy_ff <= !SUPPLY_READY ? 3'h0 : rdy_ff + {2'h0, rdy_ff != 3'h7};
         gap_ff <= rise ? 10'h000 : gap_ff + {9'h000, gap_ff != 10'h3FF};
         if (START && !BUSY)
            pc_ff <= 5'h00;
         if (rise) begin
            arm_ff <= FLASH_O.dq == `BPV_CMD_PROG_SETUP && !arm_ff;
            vfy_ff <= FLASH_O.dq == `BPV_CMD_PROG_VERIFY && !arm_ff;
            if (arm_ff) begin
               adr_ff <= FLASH_O.addr;
               pc_ff  <= FLASH_O.addr != adr_ff ? 5'h01 : pc_ff + {4'h0, pc_ff != 5'h1F};
            end
         end
      end
   end

   a_idle_bus_quiet: assert property (!BUSY |->
      FLASH_O.ce_n && FLASH_O.we_n && FLASH_O.oe_n && FLASH_O.dq_oe_n)
      else $error("bus active while idle");
   a_prog_needs_supply: assert property (
      !FLASH_O.we_n && FLASH_O.dq != `BPV_CMD_RESET |-> PROGRAM_SUPPLY_HIGH)
      else $error("write without high supply");
   a_strobe_width: assert property (
      $fell(FLASH_O.we_n) |=> !FLASH_O.we_n ##1 FLASH_O.we_n)
      else $error("write strobe width wrong");
   a_write_stable: assert property (!FLASH_O.we_n |-> !FLASH_O.ce_n
      && !FLASH_O.dq_oe_n && $stable(FLASH_O.dq) && $stable(FLASH_O.addr))
      else $error("write lines moved under strobe");
   a_read_no_drive: assert property (
      !FLASH_O.oe_n |-> FLASH_O.dq_oe_n && FLASH_O.we_n && !FLASH_O.ce_n)
      else $error("read while driving data");
   a_done_ends_op: assert property (
      DONE |-> !BUSY && !PROGRAM_SUPPLY_HIGH ##1 !DONE)
      else $error("done pulse wrong");
   a_start_clears: assert property (START && !BUSY |=> BUSY && !FAIL)
      else $error("start not taken");
   a_settle_first: assert property (
      $fell(FLASH_O.ce_n) && PROGRAM_SUPPLY_HIGH |-> rdy_ff >= 3'h4)
      else $error("command before supply settled");
   a_recovery_wait: assert property (
      $fell(FLASH_O.oe_n) && vfy_ff |-> gap_ff >= 10'h0EF)
      else $error("read inside write recovery");
   a_pulse_limit: assert property (pc_ff <= `BPV_PROG_PULSE_MAX)
      else $error("too many pulses on one byte");
   a_fail_at_limit: assert property (
      $rose(FAIL) && vfy_ff |-> pc_ff == `BPV_PROG_PULSE_MAX)
      else $error("fail before pulse limit");

   c_pass: cover property (DONE && !FAIL);
   c_fail: cover property (DONE && FAIL);
   c_verify_read: cover property ($fell(FLASH_O.oe_n) && vfy_ff);
endmodule

bind bpv_sequencer bpv_seq_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .START(START),
   .SUPPLY_READY(SUPPLY_READY), .FLASH_O(FLASH_O),
   .PROGRAM_SUPPLY_HIGH(PROGRAM_SUPPLY_HIGH), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL));

//--- bpv_flash_model.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

// mode 0 read, 1 armed, 2 pulse, 3 verify, 4 null data taken
module bpv_flash_model
   import bpv_pkg::*;
(
   input  wire bpv_flash_out_t         pins,
   input  wire logic                   supply,
   output      logic [`BPV_DATA_W-1:0] dq
);
   logic [7:0]  mem [0:65535];
   logic [15:0] la;
   logic [7:0]  pd;
   int          mode = 0;
   int          need, hits, pulses, writes;
   realtime     t_pulse, t_vfy, plen;

   // need sets how many pulses a byte takes, so retries can be commanded
   task automatic clear(input int n);
      need = n;
      hits = 0;
      pulses = 0;
      writes = 0;
   endtask

   initial begin
      dq = 8'h00;
      foreach (mem[i])
         mem[i] = 8'hFF;
      clear(1);
   end

   always @(negedge pins.we_n) begin
      if (!pins.ce_n && mode == 1)
         la = pins.addr;
   end

   always @(posedge pins.we_n) begin
      if (!pins.ce_n) begin
         writes++;
         if (mode == 1 && pins.dq != `BPV_CMD_RESET) begin
            pd = pins.dq;
            t_pulse = $realtime;
            pulses++;
            mode = 2;
         end else if (mode == 1) begin
            mode = 4;
         end else if (pins.dq == `BPV_CMD_PROG_SETUP) begin
            mode = 1;
         end else if (pins.dq == `BPV_CMD_PROG_VERIFY && mode == 2) begin
            plen = $realtime - t_pulse;
            hits++;
            // pulse length is only recorded in plen and never gates the write, so a late verify programs no deeper
            if (supply && hits >= need)
               mem[la] = mem[la] & pd;
            t_vfy = $realtime;
            mode = 3;
         end else begin
            mode = 0;
         end
      end
   end

   // a released bus inverts dq at each change of ce_n, oe_n, addr or mode, so it can show the last byte again
   always @(pins.ce_n, pins.oe_n, pins.addr, mode) begin
      if (pins.ce_n || pins.oe_n)
         dq = ~dq;
      else if (mode != 3)
         dq = mem[pins.addr];
      else if ($realtime - t_vfy < `BPV_RECOVERY_NS)
         dq = ~mem[la];
      else
         dq = mem[la];
   end
endmodule

//--- byte_program_verify_sequence_tb_top.sv
`timescale 1ns/1ps
`include "bpv_consts.svh"

module byte_program_verify_sequence_tb_top
   import bpv_pkg::*;
;
   logic           clk = 1'h0;
   logic           reset_n = 1'h0;
   logic           start = 1'h0;
   bpv_op_t        op = BPV_OP_PROG;
   logic [15:0]    addr = 16'h0000;
   logic [7:0]     data = 8'h00;
   logic           svc_req = 1'h0;
   logic           supply_ready = 1'h0;
   logic [7:0]     dq_in;
   bpv_flash_out_t flash_o;
   logic           supply_high;
   logic           busy;
   logic           done;
   logic           fail_o;
   logic [7:0]     result;
   int             failures = 0;
   int             checks = 0;

   // short erase pulse is never reached, since the whole-array preprogram is never finished here
   bpv_sequencer #(.ERASE_PULSE_CYC(20'h00014)) dut (.CLK(clk), .RESET_N(reset_n),
      .START(start), .OP(op), .ADDR(addr), .DATA(data), .SVC_REQ(svc_req),
      .SUPPLY_READY(supply_ready), .FLASH_DQ_IN(dq_in), .FLASH_O(flash_o),
      .PROGRAM_SUPPLY_HIGH(supply_high), .BUSY(busy), .DONE(done), .FAIL(fail_o),
      .RESULT(result));

   bpv_flash_model u_flash (.pins(flash_o), .supply(supply_high), .dq(dq_in));

   initial forever #12.5 clk = ~clk;

   task automatic summarize();
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic run_op(input bpv_op_t o, input logic [15:0] a, input logic [7:0] d,
                         input int need);
      int n;
      u_flash.clear(need);
      @(negedge clk);
      op = o;
      addr = a;
      data = d;
      start = 1'h1;
      @(negedge clk);
      start = 1'h0;
      repeat (2) @(negedge clk);
      supply_ready = 1'h1;
      n = 0;
      while (done !== 1'h1 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      supply_ready = 1'h0;
      if (n == 40000) begin
         failures++;
         $display("Error at %0t: operation timed out", $time);
         summarize();
      end
      @(negedge clk);
      check({busy, supply_high}, 0, "end state");
   endtask

   task automatic t_reset();
      check(flash_o.ce_n & flash_o.we_n & flash_o.oe_n & flash_o.dq_oe_n,
            1, "pins idle");
      check({busy, done, fail_o, supply_high, result}, 0, "status idle");
   endtask

   task automatic t_prog_once();
      run_op(BPV_OP_PROG, 16'h1234, 8'h5A, 1);
      check(u_flash.mem[16'h1234], 8'h5A, "programmed byte");
      check(u_flash.pulses, 1, "pulse count");
      check(u_flash.writes, 5, "write count");
      check(u_flash.plen >= `BPV_PROG_PULSE_NS, 1, "pulse length");
      check({fail_o, result}, {1'h0, 8'h5A}, "verify result");
      check(u_flash.mode, 0, "read mode");
   endtask

   task automatic t_prog_retry();
      run_op(BPV_OP_PROG, 16'h0003, 8'hA5, 3);
      check(u_flash.mem[16'h0003], 8'hA5, "reprogrammed byte");
      check(u_flash.pulses, 3, "retry pulses");
      check(u_flash.writes, 11, "retry writes");
      check(fail_o, 0, "retry fail");
   endtask

   task automatic t_prog_fail();
      run_op(BPV_OP_PROG, 16'h8000, 8'h0F, 30);
      check(u_flash.pulses, 25, "pulse limit");
      check({fail_o, result}, {1'h1, 8'hFF}, "failed byte");
      check(u_flash.mem[16'h8000], 8'hFF, "byte untouched");
   endtask

   task automatic t_svc();
      svc_req = 1'h1;
      run_op(BPV_OP_PROG, 16'hFFFF, 8'h81, 1);
      svc_req = 1'h0;
      check(u_flash.plen < `BPV_PROG_PULSE_NS, 1, "early pulse end");
      check(u_flash.mem[16'hFFFF], 8'h81, "byte after early end");
      check(fail_o, 0, "fail cleared");
   endtask

   task automatic t_abort();
      u_flash.mode = 1;
      run_op(BPV_OP_ABORT, 16'h1234, 8'h00, 1);
      check(u_flash.writes, 2, "abort writes");
      check(u_flash.mode, 0, "abort read mode");
      check(u_flash.mem[16'h1234], 8'h5A, "abort keeps array");
   endtask

   task automatic t_erase();
      u_flash.clear(1);
      @(negedge clk);
      op = BPV_OP_ERASE;
      start = 1'h1;
      supply_ready = 1'h1;
      @(negedge clk);
      start = 1'h0;
      repeat (2000) @(negedge clk);
      check(u_flash.mem[16'h0001], 8'h00, "preprogrammed byte");
      // reset in mid-operation must drop the supply and release the bus at once
      reset_n = 1'h0;
      repeat (2) @(negedge clk);
      reset_n = 1'h1;
      supply_ready = 1'h0;
      @(negedge clk);
      check({busy, done, supply_high, flash_o.ce_n}, 1, "reset mid-run");
   endtask

   initial begin
      repeat (10) @(negedge clk);
      reset_n = 1'h1;
      @(negedge clk);
      t_reset();
      t_prog_once();
      t_prog_retry();
      t_prog_fail();
      t_svc();
      t_abort();
      t_erase();
      summarize();
   end
endmodule
